// ===== pkg/accept_filter_pkg.sv
`default_nettype none
package accept_filter_pkg;
  localparam int NUM_FILTERS = 16;
  localparam int NUM_MASKS = 3;
  localparam int NUM_DEST_REGS = 4;
  localparam int NUM_MSEL_REGS = 2;
  localparam int FILTERS_PER_DEST_REG = 4;
  localparam int FILTERS_PER_MSEL_REG = 8;
  localparam int DEST_W = 4;
  localparam int MSEL_W = 2;
  localparam int SID_W = 11;
  localparam int EID_W = 18;
  localparam int EID_LO_W = 16;
  localparam int REG_W = 16;

  // Field positions inside the first pattern register of a filter or mask.
  localparam int SID_LSB = 5;
  localparam int FRAME_TYPE_BIT = 3;
  localparam int EID_HI_LSB = 0;
  localparam int EID_HI_W = 2;

  // Word indices; the byte address is four times the index.
  localparam logic [5:0] IDX_ENABLE = 6'h00;
  localparam logic [5:0] IDX_DEST0 = 6'h01;
  localparam logic [5:0] IDX_MSEL0 = 6'h05;
  localparam logic [5:0] IDX_STATUS = 6'h07;
  localparam logic [5:0] IDX_MASK0 = 6'h08;
  localparam logic [5:0] IDX_PAT0 = 6'h10;
  localparam logic [5:0] IDX_PAT_END = 6'h30;

  localparam logic [15:0] ENABLE_RST = 16'hFFFF;
  localparam logic [15:0] ZERO_RST = 16'h0000;
  // Bits 4 and 2 of the first pattern register are unimplemented.
  localparam logic [15:0] STD_REG_IMPL = 16'hFFEB;
  localparam logic [3:0] DEST_FIFO = 4'hF;
  localparam logic [1:0] MSEL_RESERVED = 2'h3;

  localparam int ST_ACC_SEEN = 8;
  localparam int ST_DISC_SEEN = 9;
endpackage
`default_nettype wire

// ===== pkg/filter_bank_if.sv
`timescale 1ns/10ps
`default_nettype none
interface filter_bank_if;
  logic [15:0] std_pat [accept_filter_pkg::NUM_FILTERS];
  logic [15:0] ext_pat [accept_filter_pkg::NUM_FILTERS];
  logic [15:0] mask_std [accept_filter_pkg::NUM_MASKS];
  logic [15:0] mask_ext [accept_filter_pkg::NUM_MASKS];
  logic [15:0] enable;
  logic [31:0] mask_source;
  logic frm_extended;
  logic [10:0] frm_sid;
  logic [17:0] frm_eid;
  logic hit;
  logic [3:0] hit_idx;

  modport cfg (
    output std_pat, ext_pat, mask_std, mask_ext, enable, mask_source,
    output frm_extended, frm_sid, frm_eid,
    input hit, hit_idx
  );
  modport match (
    input std_pat, ext_pat, mask_std, mask_ext, enable, mask_source,
    input frm_extended, frm_sid, frm_eid,
    output hit, hit_idx
  );
endinterface
`default_nettype wire

// ===== core/filter_match.sv
`timescale 1ns/10ps
`default_nettype none
module filter_match (
  filter_bank_if.match fb
);
  logic [accept_filter_pkg::NUM_FILTERS-1:0] hits;

  genvar g;
  generate
    for (g = 0; g < accept_filter_pkg::NUM_FILTERS; g++) begin : g_flt
      logic [1:0] src;
      logic [15:0] mstd;
      logic [15:0] mext;
      logic [10:0] fsid;
      logic [17:0] feid;
      logic [10:0] msid;
      logic [17:0] meid;
      logic sid_ok;
      logic eid_ok;
      logic type_ok;
      assign src = fb.mask_source[g*accept_filter_pkg::MSEL_W +: accept_filter_pkg::MSEL_W];
      assign mstd = (src == accept_filter_pkg::MSEL_RESERVED) ? accept_filter_pkg::ZERO_RST
                    : fb.mask_std[src];
      assign mext = (src == accept_filter_pkg::MSEL_RESERVED) ? accept_filter_pkg::ZERO_RST
                    : fb.mask_ext[src];
      assign fsid = fb.std_pat[g][accept_filter_pkg::SID_LSB +: accept_filter_pkg::SID_W];
      assign feid = {fb.std_pat[g][accept_filter_pkg::EID_HI_LSB +: accept_filter_pkg::EID_HI_W],
                     fb.ext_pat[g]};
      assign msid = mstd[accept_filter_pkg::SID_LSB +: accept_filter_pkg::SID_W];
      assign meid = {mstd[accept_filter_pkg::EID_HI_LSB +: accept_filter_pkg::EID_HI_W], mext};
      // A mask bit of one compares, zero is a don't-care.
      assign sid_ok = ((fsid ^ fb.frm_sid) & msid) == '0;
      // Standard frames carry no extended bits, so only the STANDARD_IDENTIFIER_PATTERN part is compared.
      assign eid_ok = !fb.frm_extended || (((feid ^ fb.frm_eid) & meid) == '0);
      assign type_ok = !mstd[accept_filter_pkg::FRAME_TYPE_BIT] ||
                       (fb.std_pat[g][accept_filter_pkg::FRAME_TYPE_BIT] == fb.frm_extended);
      // The reserved mask selection never matches, so a misprogrammed filter stays quiet.
      assign hits[g] = fb.enable[g] && (src != accept_filter_pkg::MSEL_RESERVED) &&
                       sid_ok && eid_ok && type_ok;
    end
  endgenerate

  always_comb begin
    fb.hit = |hits;
    fb.hit_idx = '0;
    for (int i = accept_filter_pkg::NUM_FILTERS - 1; i >= 0; i--) begin
      if (hits[i]) begin
        fb.hit_idx = 4'(i);
      end
    end
  end
endmodule
`default_nettype wire

// ===== core/can_acceptance_filter_bank.sv
// Operation
// - There are sixteen filters, each with a standard and an extended pattern register.
// - Enable bit n lets filter n accept; a cleared bit keeps it from ever matching.
// - A four-bit destination 0 to 14 names a receive buffer and 15 names the receive FIFO.
// - Each destination register holds four filters, lowest filter in bits 3-0, highest in 15-12.
// - Standard pattern bits 15-5 give the value each message STANDARD_IDENTIFIER_PATTERN bit must have.
// - Extended pattern bits sit at 1-0 of the first register and 15-0 of the second.
// - With a mask demanding frame type, pattern bit 3 picks extended (1) or standard (0) only.
// - A two-bit mask source picks mask 0, 1 or 2; value 3 is reserved.
// - Mask sources of filters 0 to 7 sit two bits apiece, filter 0 at 1-0, filter 7 at 15-14.
// - A mask bit of one compares that identifier bit, a mask bit of zero ignores it.
// - A mask frame-type bit of zero matches both frame types when the masked bits agree.
// - Mask sources of filters 8 to 15 sit in a second register, filter 15 at 15-14.
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module can_acceptance_filter_bank #(
  parameter int ADDR_W = 8
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADDR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic FRAME_VALID,
  input wire logic FRAME_EXTENDED,
  input wire logic [10:0] FRAME_SID,
  input wire logic [17:0] FRAME_EID,
  output logic ACCEPT_VALID,
  output logic [3:0] ACCEPT_DEST,
  output logic ACCEPT_TO_FIFO,
  output logic [3:0] ACCEPT_FILTER,
  output logic DISCARD
);
  filter_bank_if fb ();

  logic [15:0] enable_r, enable_nxt;
  logic [15:0] dest_r [accept_filter_pkg::NUM_DEST_REGS];
  logic [15:0] dest_nxt [accept_filter_pkg::NUM_DEST_REGS];
  logic [15:0] msel_r [accept_filter_pkg::NUM_MSEL_REGS];
  logic [15:0] msel_nxt [accept_filter_pkg::NUM_MSEL_REGS];
  logic [15:0] mstd_r [accept_filter_pkg::NUM_MASKS];
  logic [15:0] mstd_nxt [accept_filter_pkg::NUM_MASKS];
  logic [15:0] mext_r [accept_filter_pkg::NUM_MASKS];
  logic [15:0] mext_nxt [accept_filter_pkg::NUM_MASKS];
  logic [15:0] std_r [accept_filter_pkg::NUM_FILTERS];
  logic [15:0] std_nxt [accept_filter_pkg::NUM_FILTERS];
  logic [15:0] ext_r [accept_filter_pkg::NUM_FILTERS];
  logic [15:0] ext_nxt [accept_filter_pkg::NUM_FILTERS];

  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic acc_r, acc_nxt;
  logic disc_r, disc_nxt;
  logic [3:0] dest_out_r, dest_out_nxt;
  logic fifo_r, fifo_nxt;
  logic [3:0] filt_r, filt_nxt;
  logic acc_seen_r, acc_seen_nxt;
  logic disc_seen_r, disc_seen_nxt;

  logic access;
  logic wr;
  logic [5:0] idx;
  logic [15:0] wdat;
  logic [15:0] rval;
  logic in_pat;
  logic [3:0] pat_flt;
  logic [3:0] hit_dest;

  // Merges the two low byte lanes of a write into a 16-bit register.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] dat,
                                        input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      res[15:8] = dat[15:8];
    end
    return res;
  endfunction

  // Picks the four-bit destination field of a filter out of the bank of 16-bit destination registers.
  function automatic logic [3:0] dest_field(input logic [15:0] regs [accept_filter_pkg::NUM_DEST_REGS],
                                            input logic [3:0] flt);
    logic [15:0] word;
    word = regs[flt[3:2]];
    return word[flt[1:0]*accept_filter_pkg::DEST_W +: accept_filter_pkg::DEST_W];
  endfunction

  filter_match u_match (
    .fb(fb.match)
  );

  always_comb begin
    fb.enable = enable_r;
    fb.mask_source = {msel_r[1], msel_r[0]};
    fb.frm_extended = FRAME_EXTENDED;
    fb.frm_sid = FRAME_SID;
    fb.frm_eid = FRAME_EID;
    for (int i = 0; i < accept_filter_pkg::NUM_FILTERS; i++) begin
      fb.std_pat[i] = std_r[i];
      fb.ext_pat[i] = ext_r[i];
    end
    for (int i = 0; i < accept_filter_pkg::NUM_MASKS; i++) begin
      fb.mask_std[i] = mstd_r[i];
      fb.mask_ext[i] = mext_r[i];
    end
  end

  // Classic single cycle: the answer comes one edge after the request, and
  // ack_r itself keeps a held request from being taken twice.
  assign access = WB_CYC_I && WB_STB_I && !ack_r;
  assign wr = access && WB_WE_I;
  assign idx = WB_ADR_I[7:2];
  assign wdat = WB_DAT_I[15:0];
  assign in_pat = (idx >= accept_filter_pkg::IDX_PAT0) && (idx < accept_filter_pkg::IDX_PAT_END);
  assign pat_flt = 4'((idx - accept_filter_pkg::IDX_PAT0) >> 1);
  assign hit_dest = dest_field(dest_r, fb.hit_idx);

  // Read mux for the addressed register.
  always_comb begin
    rval = accept_filter_pkg::ZERO_RST;
    if (in_pat) begin
      rval = idx[0] ? ext_r[pat_flt] : std_r[pat_flt];
    end else if (idx == accept_filter_pkg::IDX_ENABLE) begin
      rval = enable_r;
    end else if (idx >= accept_filter_pkg::IDX_DEST0 &&
                 idx < accept_filter_pkg::IDX_MSEL0) begin
      rval = dest_r[2'(idx - accept_filter_pkg::IDX_DEST0)];
    end else if (idx >= accept_filter_pkg::IDX_MSEL0 &&
                 idx < accept_filter_pkg::IDX_STATUS) begin
      rval = msel_r[1'(idx - accept_filter_pkg::IDX_MSEL0)];
    end else if (idx == accept_filter_pkg::IDX_STATUS) begin
      rval = {6'h00, disc_seen_r, acc_seen_r, dest_out_r, filt_r};
    end else if (idx >= accept_filter_pkg::IDX_MASK0 &&
                 idx < accept_filter_pkg::IDX_PAT0) begin
      if (idx[0]) begin
        rval = mext_r[2'((idx - accept_filter_pkg::IDX_MASK0) >> 1)];
      end else begin
        rval = mstd_r[2'((idx - accept_filter_pkg::IDX_MASK0) >> 1)];
      end
    end
  end

  // Next state of the register file.
  always_comb begin
    enable_nxt = enable_r;
    for (int i = 0; i < accept_filter_pkg::NUM_DEST_REGS; i++) begin
      dest_nxt[i] = dest_r[i];
      if (wr && idx == accept_filter_pkg::IDX_DEST0 + 6'(i)) begin
        dest_nxt[i] = merge(dest_r[i], wdat, WB_SEL_I);
      end
    end
    for (int i = 0; i < accept_filter_pkg::NUM_MSEL_REGS; i++) begin
      msel_nxt[i] = msel_r[i];
      if (wr && idx == accept_filter_pkg::IDX_MSEL0 + 6'(i)) begin
        msel_nxt[i] = merge(msel_r[i], wdat, WB_SEL_I);
      end
    end
    for (int i = 0; i < accept_filter_pkg::NUM_MASKS; i++) begin
      mstd_nxt[i] = mstd_r[i];
      mext_nxt[i] = mext_r[i];
      if (wr && idx == accept_filter_pkg::IDX_MASK0 + 6'(2 * i)) begin
        mstd_nxt[i] = merge(mstd_r[i], wdat, WB_SEL_I) & accept_filter_pkg::STD_REG_IMPL;
      end
      if (wr && idx == accept_filter_pkg::IDX_MASK0 + 6'(2 * i + 1)) begin
        mext_nxt[i] = merge(mext_r[i], wdat, WB_SEL_I);
      end
    end
    for (int i = 0; i < accept_filter_pkg::NUM_FILTERS; i++) begin
      std_nxt[i] = std_r[i];
      ext_nxt[i] = ext_r[i];
      if (wr && idx == accept_filter_pkg::IDX_PAT0 + 6'(2 * i)) begin
        std_nxt[i] = merge(std_r[i], wdat, WB_SEL_I) & accept_filter_pkg::STD_REG_IMPL;
      end
      if (wr && idx == accept_filter_pkg::IDX_PAT0 + 6'(2 * i + 1)) begin
        ext_nxt[i] = merge(ext_r[i], wdat, WB_SEL_I);
      end
    end
    if (wr && idx == accept_filter_pkg::IDX_ENABLE) begin
      enable_nxt = merge(enable_r, wdat, WB_SEL_I);
    end
  end

  // Next state of the bus answer, the frame result and the status flags.
  always_comb begin
    ack_nxt = access;
    rdat_nxt = rdat_r;
    if (access) begin
      rdat_nxt = WB_WE_I ? 32'h0000_0000 : {16'h0000, rval};
    end
    acc_nxt = FRAME_VALID && fb.hit;
    // No match means no write strobe at all towards buffers or FIFO.
    disc_nxt = FRAME_VALID && !fb.hit;
    dest_out_nxt = dest_out_r;
    fifo_nxt = fifo_r;
    filt_nxt = filt_r;
    if (FRAME_VALID && fb.hit) begin
      filt_nxt = fb.hit_idx;
      dest_out_nxt = hit_dest;
      fifo_nxt = hit_dest == accept_filter_pkg::DEST_FIFO;
    end
    acc_seen_nxt = acc_seen_r;
    disc_seen_nxt = disc_seen_r;
    // Write one to clear; a new event in the same cycle wins over the clear.
    if (wr && idx == accept_filter_pkg::IDX_STATUS && WB_SEL_I[1]) begin
      if (WB_DAT_I[accept_filter_pkg::ST_ACC_SEEN]) begin
        acc_seen_nxt = 1'b0;
      end
      if (WB_DAT_I[accept_filter_pkg::ST_DISC_SEEN]) begin
        disc_seen_nxt = 1'b0;
      end
    end
    if (acc_nxt) begin
      acc_seen_nxt = 1'b1;
    end
    if (disc_nxt) begin
      disc_seen_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      enable_r <= accept_filter_pkg::ENABLE_RST;
      for (int i = 0; i < accept_filter_pkg::NUM_DEST_REGS; i++) begin
        dest_r[i] <= accept_filter_pkg::ZERO_RST;
      end
      for (int i = 0; i < accept_filter_pkg::NUM_MSEL_REGS; i++) begin
        msel_r[i] <= accept_filter_pkg::ZERO_RST;
      end
      for (int i = 0; i < accept_filter_pkg::NUM_MASKS; i++) begin
        mstd_r[i] <= accept_filter_pkg::ZERO_RST;
        mext_r[i] <= accept_filter_pkg::ZERO_RST;
      end
      for (int i = 0; i < accept_filter_pkg::NUM_FILTERS; i++) begin
        std_r[i] <= accept_filter_pkg::ZERO_RST;
        ext_r[i] <= accept_filter_pkg::ZERO_RST;
      end
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
      acc_r <= 1'b0;
      disc_r <= 1'b0;
      dest_out_r <= 4'h0;
      fifo_r <= 1'b0;
      filt_r <= 4'h0;
      acc_seen_r <= 1'b0;
      disc_seen_r <= 1'b0;
    end else begin
      enable_r <= enable_nxt;
      dest_r <= dest_nxt;
      msel_r <= msel_nxt;
      mstd_r <= mstd_nxt;
      mext_r <= mext_nxt;
      std_r <= std_nxt;
      ext_r <= ext_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
      acc_r <= acc_nxt;
      disc_r <= disc_nxt;
      dest_out_r <= dest_out_nxt;
      fifo_r <= fifo_nxt;
      filt_r <= filt_nxt;
      acc_seen_r <= acc_seen_nxt;
      disc_seen_r <= disc_seen_nxt;
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = rdat_r;
  assign ACCEPT_VALID = acc_r;
  assign ACCEPT_DEST = dest_out_r;
  assign ACCEPT_TO_FIFO = fifo_r;
  assign ACCEPT_FILTER = filt_r;
  assign DISCARD = disc_r;
endmodule
`default_nettype wire

// ===== dv/can_acceptance_filter_bank_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module can_acceptance_filter_bank_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADDR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic FRAME_VALID,
  input wire logic FRAME_EXTENDED,
  input wire logic [10:0] FRAME_SID,
  input wire logic [17:0] FRAME_EID,
  input wire logic ACCEPT_VALID,
  input wire logic [3:0] ACCEPT_DEST,
  input wire logic ACCEPT_TO_FIFO,
  input wire logic [3:0] ACCEPT_FILTER,
  input wire logic DISCARD
);
  logic [15:0] en_r;
  logic [15:0] en_nxt;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // A shadow of the enable register, so that enable effects can be tied to bus writes.
  always_comb begin
    en_nxt = en_r;
    if (WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_ADR_I[7:2] == 6'h00) begin
      if (WB_SEL_I[0]) en_nxt[7:0] = WB_DAT_I[7:0];
      if (WB_SEL_I[1]) en_nxt[15:8] = WB_DAT_I[15:8];
    end
  end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) en_r <= 16'hffff;
    else en_r <= en_nxt;
  end

  ack_after_req_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not answered in the next cycle");
  ack_has_req_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("acknowledge without a request");
  ack_one_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("acknowledge longer than one cycle");
  read_upper_zero_a: assert property (WB_ACK_O |-> WB_DAT_O[31:16] == 16'h0000)
    else $error("upper read data not zero");
  frame_answer_a: assert property (FRAME_VALID |=> ACCEPT_VALID != DISCARD)
    else $error("frame not answered by exactly one of accept or discard");
  answer_cause_a: assert property (ACCEPT_VALID || DISCARD |-> $past(FRAME_VALID))
    else $error("result pulse without a frame");
  fifo_flag_a: assert property (ACCEPT_VALID |-> ACCEPT_TO_FIFO == (ACCEPT_DEST == 4'hf))
    else $error("fifo flag disagrees with destination");
  result_hold_a: assert property (!ACCEPT_VALID |-> $stable({ACCEPT_DEST, ACCEPT_FILTER}))
    else $error("result changed without an accept");
  all_disabled_a: assert property (FRAME_VALID && en_r == 16'h0000 |=> DISCARD)
    else $error("frame accepted with every filter disabled");
  hit_enabled_a: assert property (ACCEPT_VALID |->
    (($past(en_r) >> ACCEPT_FILTER) & 16'h0001) != 16'h0000)
    else $error("accepting filter was disabled");
endmodule
`default_nettype wire

// ===== dv/can_rx_id_source.sv
`timescale 1ns/10ps
`default_nettype none
module can_rx_id_source (
  input wire logic clk,
  output logic frame_valid,
  output logic frame_extended,
  output logic [10:0] frame_sid,
  output logic [17:0] frame_eid
);
  initial begin
    frame_valid = 1'h0;
    frame_extended = 1'h0;
    frame_sid = 11'h000;
    frame_eid = 18'h0_0000;
  end

  // A standard frame carries no extended bits, so the line shows junk rather than a match.
  task automatic send(input logic ext, input logic [10:0] standard_identifier_pattern, input logic [17:0] extended_identifier_pattern);
    frame_valid <= 1'h1;
    frame_extended <= ext;
    frame_sid <= standard_identifier_pattern;
    frame_eid <= ext ? extended_identifier_pattern : ~extended_identifier_pattern;
    @(posedge clk);
  endtask

  task automatic idle();
    frame_valid <= 1'h0;
    frame_extended <= ~frame_extended;
    frame_sid <= ~frame_sid;
    frame_eid <= ~frame_eid;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== dv/can_acceptance_filter_bank_test.sv
`timescale 1ns/10ps
`default_nettype none
module can_acceptance_filter_bank_test;
  logic clk, sys_rst, wb_cyc, wb_we, wb_ack, frm_valid, frm_ext;
  logic acc_valid, acc_fifo, discard;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel, acc_dest, acc_flt;
  logic [31:0] wb_wdat, wb_rdat;
  logic [10:0] frm_sid;
  logic [17:0] frm_eid;
  logic [15:0] pstd [16], pext [16], mstd [3], mext [3], dst [4], msl [2], en;
  logic [7:0] last_e;
  logic [31:0] rd_q [$];
  logic [8:0] fr_q [$];
  int bad_count, n_checks;

  can_acceptance_filter_bank #(.ADDR_W(8)) dut_u (.CLK(clk), .SYS_RST(sys_rst),
    .WB_CYC_I(wb_cyc), .WB_STB_I(wb_cyc), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr),
    .WB_SEL_I(wb_sel), .WB_DAT_I(wb_wdat), .WB_DAT_O(wb_rdat), .WB_ACK_O(wb_ack),
    .FRAME_VALID(frm_valid), .FRAME_EXTENDED(frm_ext), .FRAME_SID(frm_sid),
    .FRAME_EID(frm_eid), .ACCEPT_VALID(acc_valid), .ACCEPT_DEST(acc_dest),
    .ACCEPT_TO_FIFO(acc_fifo), .ACCEPT_FILTER(acc_flt), .DISCARD(discard));
  can_rx_id_source src_u (.clk(clk), .frame_valid(frm_valid), .frame_extended(frm_ext),
    .frame_sid(frm_sid), .frame_eid(frm_eid));

  always #2 clk = ~clk;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_read();
    report(wb_rdat, rd_q.size() > 0 ? rd_q.pop_front() : 32'hdead_beef);
  endtask

  // Filter and destination hold on a discard, so only the pulses are compared then.
  task automatic check_frame();
    logic [8:0] e;
    logic [10:0] x;
    e = fr_q.size() > 0 ? fr_q.pop_front() : 9'h1ff;
    x = e[8] ? {2'h2, e[7:0], e[3:0] == 4'hf} : {2'h1, acc_flt, acc_dest, acc_fifo};
    report({21'h0, acc_valid, discard, acc_flt, acc_dest, acc_fifo}, {21'h0, x});
  endtask

  always @(posedge clk) begin
    if (wb_ack === 1'h1 && wb_we === 1'h0) check_read();
    if (acc_valid === 1'h1 || discard === 1'h1) check_frame();
  end

  task automatic wb_io(input logic we, input logic [5:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'h1;
    wb_we <= we;
    wb_adr <= {idx, 2'h0};
    wb_sel <= {2'($urandom), 2'h3};
    wb_wdat <= {16'($urandom), d};
    @(posedge clk);
    while (wb_ack !== 1'h1 && n < 16) begin
      n++;
      @(posedge clk);
    end
    if (n >= 16) bad_count++;
    wb_cyc <= 1'h0;
    wb_we <= 1'h0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    wb_io(1'h1, idx, d);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [15:0] e);
    rd_q.push_back({16'h0000, e});
    wb_io(1'h0, idx, 16'h0000);
  endtask

  function automatic logic [8:0] expect_frame(input logic ext, input logic [10:0] standard_identifier_pattern,
                                               input logic [17:0] extended_identifier_pattern);
    logic [1:0] ms;
    for (int f = 0; f < 16; f++) begin
      ms = msl[f / 8][(f % 8) * 2 +: 2];
      if (en[f] && ms != 2'h3 && !(mstd[ms][3] && pstd[f][3] != ext)
          && ((standard_identifier_pattern ^ pstd[f][15:5]) & mstd[ms][15:5]) == 11'h000
          && (!ext || (({pstd[f][1:0], pext[f]} ^ extended_identifier_pattern) & {mstd[ms][1:0], mext[ms]}) == 0))
        return {1'h1, 4'(f), dst[f / 4][(f % 4) * 4 +: 4]};
    end
    return 9'h000;
  endfunction

  task automatic frame(input logic ext, input logic [10:0] standard_identifier_pattern, input logic [17:0] extended_identifier_pattern);
    logic [8:0] e;
    e = expect_frame(ext, standard_identifier_pattern, extended_identifier_pattern);
    if (e[8]) last_e = e[7:0];
    fr_q.push_back(e);
    src_u.send(ext, standard_identifier_pattern, extended_identifier_pattern);
  endtask

  // Standard pattern writes carry random values in the unimplemented bits; the model keeps them cleared.
  task automatic config_random(input logic wipe);
    logic [15:0] v;
    for (int i = 0; i < 16; i++) begin
      v = 16'($urandom);
      pstd[i] = v & 16'hffeb;
      pext[i] = 16'($urandom);
      wr(accept_filter_pkg::IDX_PAT0 + 6'(2 * i), v);
      wr(accept_filter_pkg::IDX_PAT0 + 6'(2 * i + 1), pext[i]);
    end
    for (int m = 0; m < 3; m++) begin
      mstd[m] = (wipe && m == 1) ? 16'h0000 : 16'($urandom) & 16'hffeb;
      mext[m] = (wipe && m == 1) ? 16'h0000 : 16'($urandom);
      wr(accept_filter_pkg::IDX_MASK0 + 6'(2 * m), mstd[m]);
      wr(accept_filter_pkg::IDX_MASK0 + 6'(2 * m + 1), mext[m]);
    end
    for (int d = 0; d < 4; d++) begin
      dst[d] = 16'($urandom);
      wr(accept_filter_pkg::IDX_DEST0 + 6'(d), dst[d]);
    end
    for (int s = 0; s < 2; s++) begin
      msl[s] = 16'($urandom);
      wr(accept_filter_pkg::IDX_MSEL0 + 6'(s), msl[s]);
    end
    en = 16'($urandom);
    wr(accept_filter_pkg::IDX_ENABLE, en);
    for (int d = 0; d < 4; d++) rd(accept_filter_pkg::IDX_DEST0 + 6'(d), dst[d]);
    for (int s = 0; s < 2; s++) rd(accept_filter_pkg::IDX_MSEL0 + 6'(s), msl[s]);
    rd(accept_filter_pkg::IDX_PAT0 + 6'h0a, pstd[5]);
    rd(accept_filter_pkg::IDX_ENABLE, en);
  endtask

  initial begin
    int f;
    logic [28:0] id;
    clk = 1'h0;
    sys_rst = 1'h1;
    wb_cyc = 1'h0;
    wb_we = 1'h0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_wdat = 32'h0000_0000;
    bad_count = 0;
    n_checks = 0;
    last_e = 8'h00;
    void'($urandom(32'h0000_2757));
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    rd(accept_filter_pkg::IDX_ENABLE, 16'hffff);
    for (int i = 1; i < 8; i++) rd(6'(i), 16'h0000);
    rd(6'h3f, 16'h0000);
    for (int r = 0; r < 6; r++) begin
      config_random(r[0]);
      for (int k = 0; k < 32; k++) begin
        f = $urandom_range(15);
        id = {pstd[f][15:5], pstd[f][1:0], pext[f]} ^ (k[0] ? 29'h1 << $urandom_range(28) : 0);
        if (k % 8 == 7) frame(1'($urandom), 11'($urandom), 18'($urandom));
        else frame(k[2] ? pstd[f][3] : 1'($urandom), id[28:18], id[17:0]);
        if (k % 8 == 7) src_u.idle();
      end
    end
    en = 16'h0000;
    wr(accept_filter_pkg::IDX_ENABLE, en);
    // Clearing both sticky flags first shows that only the discards set one again.
    wr(accept_filter_pkg::IDX_STATUS, 16'h0300);
    for (int k = 0; k < 4; k++) frame(pstd[k][3], pstd[k][15:5], {pstd[k][1:0], pext[k]});
    src_u.idle();
    rd(accept_filter_pkg::IDX_STATUS, {6'h00, 2'h2, last_e[3:0], last_e[7:4]});
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    rd(accept_filter_pkg::IDX_ENABLE, 16'hffff);
    rd(accept_filter_pkg::IDX_DEST0, 16'h0000);
    repeat (4) @(posedge clk);
    complete_run();
  end

  initial begin
    #80000;
    bad_count++;
    complete_run();
  end
endmodule

bind can_acceptance_filter_bank can_acceptance_filter_bank_checker #(.ADDR_W(ADDR_W)) chk_u (
  .CLK(CLK), .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .FRAME_VALID(FRAME_VALID), .FRAME_EXTENDED(FRAME_EXTENDED),
  .FRAME_SID(FRAME_SID), .FRAME_EID(FRAME_EID), .ACCEPT_VALID(ACCEPT_VALID),
  .ACCEPT_DEST(ACCEPT_DEST), .ACCEPT_TO_FIFO(ACCEPT_TO_FIFO), .ACCEPT_FILTER(ACCEPT_FILTER),
  .DISCARD(DISCARD));
`default_nettype wire
